// [rtl/sel_pkg.sv]
// constants shared by the sram error logger design
package sel_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = AXI_DATA_W / 8;

  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam int             IDX_W          = AXI_ADDR_W - 2;
  localparam logic [IDX_W-1:0] IDX_EN_CLEAR = 6'h00;
  localparam logic [IDX_W-1:0] IDX_EN_SET   = 6'h01;
  localparam logic [IDX_W-1:0] IDX_FLAGS    = 6'h02;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 6'h03;
  localparam logic [IDX_W-1:0] IDX_FAULT    = 6'h04;
  localparam logic [IDX_W-1:0] IDX_DBG_CTRL = 6'h0f;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ONE_BIT_FAULT_BIT     = 0;
  localparam int DOUBLE_FAULT_BIT      = 1;
  localparam int CHECK_DISABLE_BIT     = 0;
  localparam int DBG_CHECK_DISABLE_BIT = 0;
  localparam int DEBUGGER_LOG_ENABLE   = 1;
  localparam int FAULT_LOC_W           = 17;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]            RST_IRQ_ENABLE = 2'h0;
  localparam logic [1:0]            RST_FLAGS      = 2'h0;
  localparam logic                  RST_STATUS     = 1'h0;
  localparam logic [FAULT_LOC_W-1:0] RST_FAULT_LOC = 17'h00000;
  localparam logic [1:0]            RST_DBG_CTRL   = 2'h0;

  // ---------------------------------------------------------------
  // ram geometry and code
  // ---------------------------------------------------------------
  localparam int RAM_BYTES = 4;
  localparam int RAM_DATA_W = 8 * RAM_BYTES;
  localparam int CHK_W      = 5;

  // ---------------------------------------------------------------
  // timing and responses
  // ---------------------------------------------------------------
  localparam logic [1:0] FUSE_SETTLE = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [rtl/sel_byte_codec.sv]
// single-error-correct double-error-detect codec for one data byte
`timescale 1ns/1ps
module sel_byte_codec (
  input  wire logic [7:0] i_wdata,
  output logic      [4:0] o_wchk,
  input  wire logic [7:0] i_rdata,
  input  wire logic [4:0] i_rchk,
  output logic      [7:0] o_rdata_fix,
  output logic            o_single,
  output logic            o_double
);

  // ---------------------------------------------------------------
  // encoder: hamming(12,8) plus overall parity
  // ---------------------------------------------------------------
  logic [3:0] wp;
  assign wp[0]  = i_wdata[0] ^ i_wdata[1] ^ i_wdata[3] ^ i_wdata[4] ^ i_wdata[6];
  assign wp[1]  = i_wdata[0] ^ i_wdata[2] ^ i_wdata[3] ^ i_wdata[5] ^ i_wdata[6];
  assign wp[2]  = i_wdata[1] ^ i_wdata[2] ^ i_wdata[3] ^ i_wdata[7];
  assign wp[3]  = i_wdata[4] ^ i_wdata[5] ^ i_wdata[6] ^ i_wdata[7];
  assign o_wchk = {(^i_wdata) ^ (^wp), wp};

  // ---------------------------------------------------------------
  // decoder
  // ---------------------------------------------------------------
  logic [3:0]  rp;
  logic [3:0]  syn;
  logic        par_bad;
  logic [12:1] cw;
  logic [12:1] flip;
  logic [12:1] cw_fix;
  assign rp[0]   = i_rdata[0] ^ i_rdata[1] ^ i_rdata[3] ^ i_rdata[4] ^ i_rdata[6];
  assign rp[1]   = i_rdata[0] ^ i_rdata[2] ^ i_rdata[3] ^ i_rdata[5] ^ i_rdata[6];
  assign rp[2]   = i_rdata[1] ^ i_rdata[2] ^ i_rdata[3] ^ i_rdata[7];
  assign rp[3]   = i_rdata[4] ^ i_rdata[5] ^ i_rdata[6] ^ i_rdata[7];
  assign syn     = rp ^ i_rchk[3:0];
  assign par_bad = (^i_rdata) ^ (^i_rchk);
  assign cw      = {i_rdata[7:4], i_rchk[3], i_rdata[3:1], i_rchk[2], i_rdata[0],
                    i_rchk[1], i_rchk[0]};
  // syndrome above 12 cannot come from one flip; mask keeps it harmless
  assign flip    = (par_bad && syn != 4'h0) ? 12'((13'h0001 << syn) >> 1) : 12'h000;
  assign cw_fix  = cw ^ flip;
  assign o_rdata_fix = {cw_fix[12:9], cw_fix[7:5], cw_fix[3]};
  assign o_single    = par_bad;
  assign o_double    = !par_bad && syn != 4'h0;

endmodule

// [rtl/sel_top.sv]
// error logging, register slave and checked ram path of the sram check unit
`timescale 1ns/1ps
module sel_top #(
  parameter int RAM_ADDR_W = sel_pkg::FAULT_LOC_W,
  parameter int RAM_BYTES  = sel_pkg::RAM_BYTES
) (
  input  wire logic                             I_REF_CLK,
  input  wire logic                             I_RSTN,
  // axi4-lite slave
  input  wire logic [sel_pkg::AXI_ADDR_W-1:0]   I_AWADDR,
  input  wire logic                             I_AWVALID,
  output logic                                  O_AWREADY,
  input  wire logic [sel_pkg::AXI_DATA_W-1:0]   I_WDATA,
  input  wire logic [sel_pkg::AXI_STRB_W-1:0]   I_WSTRB,
  input  wire logic                             I_WVALID,
  output logic                                  O_WREADY,
  output logic [1:0]                            O_BRESP,
  output logic                                  O_BVALID,
  input  wire logic                             I_BREADY,
  input  wire logic [sel_pkg::AXI_ADDR_W-1:0]   I_ARADDR,
  input  wire logic                             I_ARVALID,
  output logic                                  O_ARREADY,
  output logic [sel_pkg::AXI_DATA_W-1:0]        O_RDATA,
  output logic [1:0]                            O_RRESP,
  output logic                                  O_RVALID,
  input  wire logic                             I_RREADY,
  // system side
  input  wire logic                             I_WRITE_PROTECT,
  input  wire logic                             I_FUSE_CHECK_DIS,
  output logic                                  O_IRQ,
  // ram requests from the system
  input  wire logic                             I_RAM_WE,
  input  wire logic                             I_RAM_RE,
  input  wire logic                             I_RAM_DBG,
  input  wire logic [RAM_ADDR_W-1:0]            I_RAM_ADDR,
  input  wire logic [8*RAM_BYTES-1:0]           I_RAM_WDATA,
  output logic [8*RAM_BYTES-1:0]                O_RAM_RDATA,
  output logic                                  O_RAM_RVALID,
  // sram array
  output logic                                  O_MEM_WE,
  output logic                                  O_MEM_CHK_WE,
  output logic                                  O_MEM_RE,
  output logic [RAM_ADDR_W-1:0]                 O_MEM_ADDR,
  output logic [8*RAM_BYTES-1:0]                O_MEM_WDATA,
  output logic [sel_pkg::CHK_W*RAM_BYTES-1:0]   O_MEM_WCHK,
  input  wire logic                             I_MEM_RVALID,
  input  wire logic [8*RAM_BYTES-1:0]           I_MEM_RDATA,
  input  wire logic [sel_pkg::CHK_W*RAM_BYTES-1:0] I_MEM_RCHK
);
  import sel_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0]             irq_enable;
  logic [1:0]             error_flags;
  logic                   check_disable_bit;
  logic [RAM_ADDR_W-1:0]  fault_location;
  logic [1:0]             debugger_read_control;
  logic                   fuse_s1;
  logic                   fuse_s2;
  logic [1:0]             fuse_cnt;
  logic [AXI_ADDR_W-1:0]  aw_addr;
  logic [AXI_DATA_W-1:0]  w_data;
  logic [AXI_STRB_W-1:0]  w_strb;
  logic [RAM_ADDR_W-1:0]  pend_addr;
  logic                   pend_dbg;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] wr_idx;
  logic             wr_fire;
  logic             wr_lane0;
  logic             wr_mapped;
  logic             wr_guarded;
  logic             wr_blocked;
  logic [1:0]       wr_bits;
  logic [1:0]       en_set;
  logic [1:0]       en_clr;
  logic [1:0]       flag_clr_w;
  logic             dbg_wr;

  assign wr_idx     = aw_addr[AXI_ADDR_W-1:2];
  assign wr_fire    = !O_AWREADY && !O_WREADY && !O_BVALID;
  // control bits live in lane 0, so any access size reaching it works
  assign wr_lane0   = wr_fire && w_strb[0];
  assign wr_bits    = w_data[1:0];
  assign wr_mapped  = wr_idx == IDX_EN_CLEAR || wr_idx == IDX_EN_SET ||
                      wr_idx == IDX_FLAGS || wr_idx == IDX_STATUS ||
                      wr_idx == IDX_FAULT || wr_idx == IDX_DBG_CTRL;
  assign wr_guarded = wr_idx == IDX_EN_CLEAR || wr_idx == IDX_EN_SET ||
                      wr_idx == IDX_DBG_CTRL;
  assign wr_blocked = I_WRITE_PROTECT && wr_guarded;
  assign en_set     = (wr_lane0 && !wr_blocked && wr_idx == IDX_EN_SET) ?
                      wr_bits : 2'h0;
  assign en_clr     = (wr_lane0 && !wr_blocked && wr_idx == IDX_EN_CLEAR) ?
                      wr_bits : 2'h0;
  assign flag_clr_w = (wr_lane0 && wr_idx == IDX_FLAGS) ? wr_bits : 2'h0;
  assign dbg_wr     = wr_lane0 && !wr_blocked && wr_idx == IDX_DBG_CTRL;

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  logic [IDX_W-1:0]      rd_idx;
  logic                  ar_fire;
  logic                  rd_mapped;
  logic                  rd_clr;
  logic [AXI_DATA_W-1:0] loc_view;
  logic [AXI_DATA_W-1:0] rd_word;

  assign rd_idx    = I_ARADDR[AXI_ADDR_W-1:2];
  assign ar_fire   = I_ARVALID && O_ARREADY;
  assign rd_mapped = rd_idx == IDX_EN_CLEAR || rd_idx == IDX_EN_SET ||
                     rd_idx == IDX_FLAGS || rd_idx == IDX_STATUS ||
                     rd_idx == IDX_FAULT || rd_idx == IDX_DBG_CTRL;
  assign rd_clr    = ar_fire && rd_idx == IDX_FAULT;
  assign loc_view  = (error_flags == 2'h0) ? 32'h00000000 :
                     32'(fault_location);
  assign rd_word   = (rd_idx == IDX_EN_CLEAR || rd_idx == IDX_EN_SET) ?
                     {30'h00000000, irq_enable} :
                     (rd_idx == IDX_FLAGS)    ? {30'h00000000, error_flags} :
                     (rd_idx == IDX_STATUS)   ? {31'h00000000, check_disable_bit} :
                     (rd_idx == IDX_FAULT)    ? loc_view :
                     (rd_idx == IDX_DBG_CTRL) ? {30'h00000000, debugger_read_control} :
                     32'h00000000;

  // ---------------------------------------------------------------
  // checked ram read path
  // ---------------------------------------------------------------
  logic [8*RAM_BYTES-1:0]     fix_data;
  logic [CHK_W*RAM_BYTES-1:0] enc_chk;
  logic [RAM_BYTES-1:0]       byte_single;
  logic [RAM_BYTES-1:0]       byte_double;
  logic                       dbg_off;
  logic                       no_fix;
  logic                       log_ok;
  logic                       sgl_ev;
  logic                       dbl_ev;

  genvar gb;
  generate
    for (gb = 0; gb < RAM_BYTES; gb++) begin : g_byte
      sel_byte_codec u_codec (
        .i_wdata     (I_RAM_WDATA[8*gb +: 8]),
        .o_wchk      (enc_chk[CHK_W*gb +: CHK_W]),
        .i_rdata     (I_MEM_RDATA[8*gb +: 8]),
        .i_rchk      (I_MEM_RCHK[CHK_W*gb +: CHK_W]),
        .o_rdata_fix (fix_data[8*gb +: 8]),
        .o_single    (byte_single[gb]),
        .o_double    (byte_double[gb])
      );
    end
  endgenerate

  assign dbg_off = pend_dbg && debugger_read_control[DBG_CHECK_DISABLE_BIT];
  assign no_fix  = check_disable_bit || dbg_off;
  // debugger reads log only when asked to, so a halted probe leaves no trace
  assign log_ok  = !no_fix && (!pend_dbg ||
                   debugger_read_control[DEBUGGER_LOG_ENABLE]);
  assign dbl_ev  = I_MEM_RVALID && log_ok && (|byte_double);
  assign sgl_ev  = I_MEM_RVALID && log_ok && (|byte_single) && !(|byte_double);

  // ---------------------------------------------------------------
  // flags, enables and capture
  // ---------------------------------------------------------------
  logic [1:0]            ev;
  logic [1:0]            clr_mask;
  logic [1:0]            kept_flags;
  logic [1:0]            next_flags;
  logic [1:0]            next_enable;
  logic                  cap;
  logic [RAM_ADDR_W-1:0] next_location;

  assign ev            = {dbl_ev, sgl_ev};
  assign clr_mask      = flag_clr_w | {2{rd_clr}};
  assign kept_flags    = error_flags & ~clr_mask;
  // an error in the clearing cycle survives: set wins
  assign next_flags    = kept_flags | ev;
  assign next_enable   = (irq_enable | en_set) & ~en_clr;
  assign cap           = ((sgl_ev || dbl_ev) && kept_flags == 2'h0) ||
                         (dbl_ev && !kept_flags[DOUBLE_FAULT_BIT]);
  assign next_location = cap ? pend_addr : fault_location;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      irq_enable            <= RST_IRQ_ENABLE;
      error_flags           <= RST_FLAGS;
      fault_location        <= RST_FAULT_LOC;
      debugger_read_control <= RST_DBG_CTRL;
      O_IRQ                 <= 1'b0;
    end else begin
      irq_enable     <= next_enable;
      error_flags    <= next_flags;
      fault_location <= next_location;
      if (dbg_wr) begin
        debugger_read_control <= wr_bits;
      end
      O_IRQ <= |(next_flags & next_enable);
    end
  end

  // ---------------------------------------------------------------
  // fuse capture
  // ---------------------------------------------------------------
  // sampled after the synchroniser has settled, then held until reset
  always_ff @(posedge I_REF_CLK) begin
    fuse_s1 <= I_FUSE_CHECK_DIS;
    fuse_s2 <= fuse_s1;
    if (!I_RSTN) begin
      fuse_cnt          <= 2'h0;
      check_disable_bit <= RST_STATUS;
    end else if (fuse_cnt != FUSE_SETTLE) begin
      fuse_cnt <= fuse_cnt + 2'h1;
      if (fuse_cnt == FUSE_SETTLE - 2'h1) begin
        check_disable_bit <= fuse_s2;
      end
    end
  end

  // ---------------------------------------------------------------
  // ram request path
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_MEM_WE     <= 1'b0;
      O_MEM_CHK_WE <= 1'b0;
      O_MEM_RE     <= 1'b0;
      O_MEM_ADDR   <= '0;
      O_MEM_WDATA  <= '0;
      O_MEM_WCHK   <= '0;
      O_RAM_RDATA  <= '0;
      O_RAM_RVALID <= 1'b0;
      pend_addr    <= '0;
      pend_dbg     <= 1'b0;
    end else begin
      O_MEM_WE     <= I_RAM_WE;
      O_MEM_CHK_WE <= I_RAM_WE && !check_disable_bit;
      O_MEM_RE     <= I_RAM_RE && !I_RAM_WE;
      O_MEM_ADDR   <= I_RAM_ADDR;
      O_MEM_WDATA  <= I_RAM_WDATA;
      O_MEM_WCHK   <= enc_chk;
      O_RAM_RVALID <= I_MEM_RVALID;
      if (I_MEM_RVALID) begin
        O_RAM_RDATA <= no_fix ? I_MEM_RDATA : fix_data;
      end
      if (I_RAM_RE && !I_RAM_WE) begin
        pend_addr <= I_RAM_ADDR;
        pend_dbg  <= I_RAM_DBG;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_AWREADY <= 1'b1;
      O_WREADY  <= 1'b1;
      O_BVALID  <= 1'b0;
      O_BRESP   <= RESP_OKAY;
      aw_addr   <= '0;
      w_data    <= '0;
      w_strb    <= '0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_addr   <= I_AWADDR;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_data   <= I_WDATA;
        w_strb   <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= (!wr_mapped || wr_blocked) ? RESP_SLVERR : RESP_OKAY;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID  <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= '0;
      O_RRESP   <= RESP_OKAY;
    end else if (ar_fire) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b1;
      O_RDATA   <= rd_word;
      O_RRESP   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID  <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

endmodule

// [bench/sel_checker.sv]
// port-level assertions for the sram error logger
`timescale 1ns/1ps
module sel_checker #(
  parameter int RAM_ADDR_W = sel_pkg::FAULT_LOC_W
) (
  input wire logic                           I_REF_CLK,
  input wire logic                           I_RSTN,
  input wire logic                           I_AWVALID,
  input wire logic                           O_AWREADY,
  input wire logic                           I_WVALID,
  input wire logic                           O_WREADY,
  input wire logic                           O_BVALID,
  input wire logic                           I_BREADY,
  input wire logic [sel_pkg::AXI_ADDR_W-1:0] I_ARADDR,
  input wire logic                           I_ARVALID,
  input wire logic                           O_ARREADY,
  input wire logic                           O_RVALID,
  input wire logic                           I_RREADY,
  input wire logic                           O_IRQ,
  input wire logic                           I_RAM_WE,
  input wire logic                           I_RAM_RE,
  input wire logic [RAM_ADDR_W-1:0]          I_RAM_ADDR,
  input wire logic                           O_MEM_WE,
  input wire logic                           O_MEM_CHK_WE,
  input wire logic                           O_MEM_RE,
  input wire logic [RAM_ADDR_W-1:0]          O_MEM_ADDR,
  input wire logic                           I_MEM_RVALID,
  input wire logic                           O_RAM_RVALID
);
  import sel_pkg::*;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  // ---------------------------------------------------------------
  // bus, ram path and interrupt
  // ---------------------------------------------------------------
  property p_b_stand; O_BVALID && !I_BREADY |=> O_BVALID; endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  property p_b_after; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
    |=> !O_AWREADY ##[0:1] O_BVALID; endproperty
  a_b_after: assert property (p_b_after) else $error("write response missing");
  property p_r_after; I_ARVALID && O_ARREADY |=> !O_ARREADY ##[0:1] O_RVALID; endproperty
  a_r_after: assert property (p_r_after) else $error("read response missing");
  property p_r_stand; O_RVALID && !I_RREADY |=> O_RVALID && !O_ARREADY; endproperty
  a_r_stand: assert property (p_r_stand) else $error("read response dropped");
  property p_mem_we; I_RAM_WE |=> O_MEM_WE && O_MEM_ADDR == $past(I_RAM_ADDR); endproperty
  a_mem_we: assert property (p_mem_we) else $error("array write missing");
  property p_mem_re; I_RAM_RE && !I_RAM_WE |=> O_MEM_RE && !O_MEM_WE; endproperty
  a_mem_re: assert property (p_mem_re) else $error("array read missing");
  property p_ram_rv; I_MEM_RVALID |=> O_RAM_RVALID; endproperty
  a_ram_rv: assert property (p_ram_rv) else $error("read return missing");
  property p_chk_we; O_MEM_CHK_WE |-> O_MEM_WE; endproperty
  a_chk_we: assert property (p_chk_we) else $error("check write without data");
  property p_irq_clr; (I_ARVALID && O_ARREADY && I_ARADDR == 8'h10 && !I_MEM_RVALID)
    ##1 !I_MEM_RVALID |=> !O_IRQ; endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq kept after clear");
endmodule
bind sel_top sel_checker #(.RAM_ADDR_W(RAM_ADDR_W)) sel_checker_inst (
  .I_REF_CLK, .I_RSTN, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID,
  .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY, .O_IRQ,
  .I_RAM_WE, .I_RAM_RE, .I_RAM_ADDR, .O_MEM_WE, .O_MEM_CHK_WE, .O_MEM_RE,
  .O_MEM_ADDR, .I_MEM_RVALID, .O_RAM_RVALID
);

// [bench/sel_sram_model.sv]
// behavioural sram array with fault injection on read return
`timescale 1ns/1ps
module sel_sram_model (
  input  wire logic        i_clk,
  input  wire logic        i_we,
  input  wire logic        i_chk_we,
  input  wire logic        i_re,
  input  wire logic [16:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [19:0] i_wchk,
  input  wire logic [51:0] i_flip,
  input  wire logic [1:0]  i_lat,
  output logic             o_rvalid,
  output logic [31:0]      o_rdata,
  output logic [19:0]      o_rchk
);
  logic [31:0] dat_mem [16];
  logic [19:0] chk_mem [16];
  logic [3:0]  idx;
  logic [2:0]  wait_cnt = 3'h0;
  initial o_rvalid = 1'b0;
  initial o_rdata = 32'h0;
  initial o_rchk = 20'h0;
  // ---------------------------------------------------------------
  // array: only 16 words, aliased on the low address bits
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    o_rvalid <= 1'b0;
    // idle lines toggle so a stale word is never mistaken for data
    o_rdata <= ~o_rdata;
    o_rchk <= ~o_rchk;
    if (i_we) dat_mem[i_addr[3:0]] <= i_wdata;
    if (i_chk_we) chk_mem[i_addr[3:0]] <= i_wchk;
    if (i_re) begin
      idx <= i_addr[3:0];
      wait_cnt <= {1'b0, i_lat} + 3'h1;
    end else if (wait_cnt == 3'h1) begin
      o_rvalid <= 1'b1;
      {o_rchk, o_rdata} <= {chk_mem[idx], dat_mem[idx]} ^ i_flip;
      wait_cnt <= 3'h0;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end
  end
endmodule

// [bench/tb_sel_top.sv]
// self-checking bench for the sram error logger
`timescale 1ns/1ps
module tb_sel_top;
  import sel_pkg::*;
  logic        clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic        wp = 0, fuse = 0, rwe = 0, rre = 0, rdbg = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rwdata = 0, q, d, r, seed = 32'h00009a0f;
  logic [3:0]  wstrb = 0;
  logic [16:0] raddr = 0, a, a0;
  logic [51:0] flip = 0;
  logic [1:0]  lat = 0;
  logic [19:0] chk0;
  logic [7:0]  regs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h3c};
  wire         awrdy, wrdy, bvalid, arrdy, rvalid, irq, rrv, mwe, mcwe, mre, mrv;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata, rrdata, mwdata, mrdata;
  wire  [16:0] maddr;
  wire  [19:0] mwchk, mrchk;
  int          failures = 0, checks = 0, cycles = 0;
  sel_top sel_top_inst (.I_REF_CLK(clk), .I_RSTN(rstn), .I_AWADDR(awaddr), .I_AWVALID(awv),
    .O_AWREADY(awrdy), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wv), .O_WREADY(wrdy),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arv), .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready), .I_WRITE_PROTECT(wp), .I_FUSE_CHECK_DIS(fuse),
    .O_IRQ(irq), .I_RAM_WE(rwe), .I_RAM_RE(rre), .I_RAM_DBG(rdbg), .I_RAM_ADDR(raddr),
    .I_RAM_WDATA(rwdata), .O_RAM_RDATA(rrdata), .O_RAM_RVALID(rrv), .O_MEM_WE(mwe),
    .O_MEM_CHK_WE(mcwe), .O_MEM_RE(mre), .O_MEM_ADDR(maddr), .O_MEM_WDATA(mwdata),
    .O_MEM_WCHK(mwchk), .I_MEM_RVALID(mrv), .I_MEM_RDATA(mrdata), .I_MEM_RCHK(mrchk));
  sel_sram_model sel_sram_model_inst (.i_clk(clk), .i_we(mwe), .i_chk_we(mcwe), .i_re(mre),
    .i_addr(maddr), .i_wdata(mwdata), .i_wchk(mwchk), .i_flip(flip), .i_lat(lat),
    .o_rvalid(mrv), .o_rdata(mrdata), .o_rchk(mrchk));
  initial forever #20 clk = ~clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // ready goes up with the request and stays up
  task automatic wr(input logic [7:0] ad, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] er);
    awaddr <= ad;
    wdata <= v;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (bvalid && bready) break;
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
    araddr <= ad;
    arv <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (rvalid && rready) break;
      if (arrdy) arv <= 1'b0;
    end
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic ram_wr(input logic [16:0] ad, input logic [31:0] v);
    rwe <= 1'b1;
    raddr <= ad;
    rwdata <= v;
    @(posedge clk);
    rwe <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ram_rd(input logic [16:0] ad, input logic g, input logic [51:0] f);
    r = rnd();
    lat <= r[1:0];
    flip <= f;
    rre <= 1'b1;
    rdbg <= g;
    raddr <= ad;
    @(posedge clk);
    rre <= 1'b0;
    do @(posedge clk); while (!rrv);
    q = rrdata;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    foreach (regs[i]) rd(regs[i], 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'hffffffff, 4'hf, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_OKAY);
    $display("test reset values done");
    wr(8'h04, 32'h1, 4'hf, RESP_OKAY);
    rd(8'h00, 32'h1, RESP_OKAY);
    wr(8'h04, 32'h2, 4'h2, RESP_OKAY);
    rd(8'h04, 32'h1, RESP_OKAY);
    wr(8'h04, 32'hfffffffe, 4'hf, RESP_OKAY);
    rd(8'h04, 32'h3, RESP_OKAY);
    wr(8'h00, 32'hfffffffd, 4'hf, RESP_OKAY);
    rd(8'h04, 32'h2, RESP_OKAY);
    wp <= 1'b1;
    wr(8'h00, 32'h2, 4'hf, RESP_SLVERR);
    wr(8'h3c, 32'h1, 4'hf, RESP_SLVERR);
    rd(8'h3c, 32'h0, RESP_OKAY);
    wp <= 1'b0;
    rd(8'h00, 32'h2, RESP_OKAY);
    $display("test enables done");
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      a = {r[16:4], 4'(i)};
      if (i == 0) a0 = a;
      d = rnd();
      ram_wr(a, d);
      r = rnd();
      ram_rd(a, 1'b0, 52'h1 << (r % 52));
      chk(q, d);
    end
    chk({31'h0, irq}, 32'h0);
    rd(8'h08, 32'h1, RESP_OKAY);
    wr(8'h04, 32'h1, 4'hf, RESP_OKAY);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h00, 32'h1, 4'hf, RESP_OKAY);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(8'h10, {15'h0, a0}, RESP_OKAY);
    rd(8'h08, 32'h0, RESP_OKAY);
    ram_rd(a0, 1'b0, 52'h1 << 40);
    a = a0 ^ 17'h10000;
    ram_wr(a, d);
    ram_rd(a, 1'b0, 52'h3 << 8);
    rd(8'h08, 32'h3, RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    wr(8'h08, 32'h0, 4'hf, RESP_OKAY);
    rd(8'h08, 32'h3, RESP_OKAY);
    ram_rd(a0, 1'b0, 52'h1 << 20);
    rd(8'h10, {15'h0, a}, RESP_OKAY);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(8'h10, 32'h0, RESP_OKAY);
    $display("test error logging done");
    d = rnd();
    ram_wr(a0, d);
    for (int m = 0; m < 4; m++) begin
      wr(8'h3c, 32'(m), 4'hf, RESP_OKAY);
      rd(8'h3c, 32'(m), RESP_OKAY);
      ram_rd(a0, 1'b1, 52'h10);
      chk(q, (m % 2 == 1) ? d ^ 32'h10 : d);
      rd(8'h08, (m == 2) ? 32'h1 : 32'h0, RESP_OKAY);
      rd(8'h10, (m == 2) ? {15'h0, a0} : 32'h0, RESP_OKAY);
    end
    $display("test debugger reads done");
    fuse <= 1'b1;
    do_reset();
    rd(8'h0c, 32'h1, RESP_OKAY);
    chk0 = sel_sram_model_inst.chk_mem[a0[3:0]];
    d = rnd();
    ram_wr(a0, d);
    @(posedge clk);
    chk({12'h0, sel_sram_model_inst.chk_mem[a0[3:0]]}, {12'h0, chk0});
    ram_rd(a0, 1'b0, 52'h1);
    chk(q, d ^ 32'h1);
    rd(8'h08, 32'h0, RESP_OKAY);
    $display("test fuse disable done");
    give_verdict();
  end
endmodule
